/* hw/rta_pkg.sv */
// constants for the retimer adaptation and interrupt configuration bank
package rta_pkg;
  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_LOSS_OBS   = 8'h01;
  localparam logic [7:0] IDX_CTRL       = 8'h31;
  localparam logic [7:0] IDX_EYE_IRQ    = 8'h32;
  localparam logic [7:0] IDX_DFE_MIN    = 8'h33;
  localparam logic [7:0] IDX_IRQ_STATUS = 8'h40;
  localparam logic [7:0] IDX_IRQ_MASK   = 8'h41;
  localparam logic [7:0] IDX_AUX_CTRL   = 8'h42;
  localparam logic [7:0] IDX_ALT_FOM    = 8'h6E;

  localparam int ADDR_W = 12;
  localparam int DATA_W = 32;

  // fields of the control register
  localparam int CTRL_PAT_IRQ_EN  = 7;
  localparam int CTRL_POLICY_LSB  = 5;
  localparam int CTRL_MERIT_LSB   = 3;
  localparam int CTRL_LOCK_IRQ_EN = 1;
  localparam int CTRL_LOSS_IRQ_EN = 0;

  // fields of the threshold registers
  localparam int THR_H_LSB = 4;
  localparam int THR_V_LSB = 0;

  // loss observation bits
  localparam int OBS_LOCK_LOSS = 5;
  localparam int OBS_SIG_LOSS  = 0;

  // aux control fields and the alternate merit bit
  localparam int AUX_START       = 0;
  localparam int AUX_EYE_IRQ_EN  = 1;
  localparam int ALT_FOM_BIT     = 7;

  // interrupt status layout
  localparam int IRQ_W          = 4;
  localparam int IRQ_SIG_LOSS   = 0;
  localparam int IRQ_LOCK_LOSS  = 1;
  localparam int IRQ_EYE_LOW    = 2;
  localparam int IRQ_PATTERN    = 3;

  // reset values
  localparam logic [7:0] RST_CTRL    = 8'h20;
  localparam logic [7:0] RST_EYE_IRQ = 8'h11;
  localparam logic [7:0] RST_DFE_MIN = 8'h88;
  localparam logic [7:0] RST_AUX     = 8'h00;
  localparam logic [7:0] RST_ALT_FOM = 8'h00;
  localparam logic [IRQ_W-1:0] RST_IRQ = 4'h0;

  // one threshold step equals eight eye counts (shift amount of three)
  localparam int EYE_STEP_SHIFT = 3;

  // adaptation policy codes
  localparam logic [1:0] POL_OFF      = 2'h0;
  localparam logic [1:0] POL_CTLE     = 2'h1;
  localparam logic [1:0] POL_CTLE_DFE = 2'h2;
  localparam logic [1:0] POL_LOCK_DFE = 2'h3;

  // merit selection codes
  localparam logic [1:0] MER_BOTH_A = 2'h0;
  localparam logic [1:0] MER_H      = 2'h1;
  localparam logic [1:0] MER_V      = 2'h2;
  localparam logic [1:0] MER_BOTH_B = 2'h3;

  typedef enum logic [2:0] {
    SQ_IDLE  = 3'b000,
    SQ_CTLE  = 3'b001,
    SQ_DFE   = 3'b010,
    SQ_CTLE2 = 3'b011,
    SQ_EQ    = 3'b100,
    SQ_DONE  = 3'b101
  } rta_seq_state_t;
endpackage

/* hw/rta_eye_cmp.sv */
// eye opening compare against a pair of four bit thresholds scaled by eight
`timescale 1ns/100ps
module rta_eye_cmp
(
  input  wire logic [7:0] horizontal_eye_opening,
  input  wire logic [7:0] vertical_eye_opening,
  input  wire logic [3:0] level_h,
  input  wire logic [3:0] level_v,
  output logic            h_ok,
  output logic            v_ok
);
  logic [7:0] scaled_h;
  logic [7:0] scaled_v;

  always_comb
  begin
    scaled_h = 8'({1'b0, level_h} << rta_pkg::EYE_STEP_SHIFT);
    scaled_v = 8'({1'b0, level_v} << rta_pkg::EYE_STEP_SHIFT);
    h_ok     = horizontal_eye_opening >= scaled_h;
    v_ok     = vertical_eye_opening >= scaled_v;
  end
endmodule

/* hw/rta_adapt_seq.sv */
// equalizer adaptation sequencer driven by the selected policy
`timescale 1ns/100ps
module rta_adapt_seq
(
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] policy,
  input  wire logic       start,
  input  wire logic       cdr_lock,
  input  wire logic       eye_min_met,
  input  wire logic       ctle_done,
  input  wire logic       dfe_done,
  output logic            ctle_adapt_q,
  output logic            dfe_adapt_q,
  output logic            eq_final_adapt_q,
  output logic            busy_q
);
  rta_pkg::rta_seq_state_t state_q;
  rta_pkg::rta_seq_state_t state_d;

  always_comb
  begin
    state_d = state_q;
    if (policy == rta_pkg::POL_OFF)
      state_d = rta_pkg::SQ_IDLE;
    else if (start)
      state_d = rta_pkg::SQ_CTLE;
    else
    begin
      unique case (state_q)
        rta_pkg::SQ_IDLE:  state_d = rta_pkg::SQ_IDLE;
        rta_pkg::SQ_CTLE:
        begin
          if (policy == rta_pkg::POL_LOCK_DFE)
          begin
            if (cdr_lock && eye_min_met)
              state_d = rta_pkg::SQ_DFE;
          end
          else if (ctle_done)
            state_d = (policy == rta_pkg::POL_CTLE) ? rta_pkg::SQ_DONE : rta_pkg::SQ_DFE;
        end
        rta_pkg::SQ_DFE:
          if (dfe_done)
            state_d = (policy == rta_pkg::POL_LOCK_DFE) ? rta_pkg::SQ_EQ : rta_pkg::SQ_CTLE2;
        rta_pkg::SQ_CTLE2: if (ctle_done) state_d = rta_pkg::SQ_DONE;
        rta_pkg::SQ_EQ:    if (ctle_done) state_d = rta_pkg::SQ_DONE;
        rta_pkg::SQ_DONE:  state_d = rta_pkg::SQ_DONE;
        default:           state_d = rta_pkg::SQ_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      state_q          <= rta_pkg::SQ_IDLE;
      ctle_adapt_q     <= 1'b0;
      dfe_adapt_q      <= 1'b0;
      eq_final_adapt_q <= 1'b0;
      busy_q           <= 1'b0;
    end
    else
    begin
      state_q          <= state_d;
      ctle_adapt_q     <= (state_d == rta_pkg::SQ_CTLE) || (state_d == rta_pkg::SQ_CTLE2);
      dfe_adapt_q      <= (state_d == rta_pkg::SQ_DFE);
      eq_final_adapt_q <= (state_d == rta_pkg::SQ_EQ);
      busy_q           <= (state_d != rta_pkg::SQ_IDLE) && (state_d != rta_pkg::SQ_DONE);
    end
  end
endmodule

/* hw/rta_bank.sv */
// register bank for interrupt enables, adaptation policy and eye thresholds
//
// Added by the designer: the APB register port.
`timescale 1ns/100ps
module rta_bank
(
  input  wire logic        clk,
  input  wire logic        rst,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        pattern_error_pulse,
  input  wire logic        cdr_lock,
  input  wire logic        signal_detect,
  input  wire logic        eye_valid,
  input  wire logic [7:0]  horizontal_eye_opening,
  input  wire logic [7:0]  vertical_eye_opening,
  input  wire logic        ctle_done,
  input  wire logic        dfe_done,
  output logic             irq,
  output logic             ctle_adapt,
  output logic             dfe_adapt,
  output logic             eq_final_adapt,
  output logic             adapt_busy,
  output logic             merit_use_horizontal,
  output logic             merit_use_vertical,
  output logic             merit_use_alternate
);
  // register state
  logic [7:0]              ctrl_q;
  logic [7:0]              ctrl_d;
  logic [7:0]              eye_irq_q;
  logic [7:0]              eye_irq_d;
  logic [7:0]              dfe_min_q;
  logic [7:0]              dfe_min_d;
  logic [7:0]              aux_q;
  logic [7:0]              aux_d;
  logic [7:0]              alt_q;
  logic [7:0]              alt_d;
  logic [rta_pkg::IRQ_W-1:0] status_q;
  logic [rta_pkg::IRQ_W-1:0] status_d;
  logic [rta_pkg::IRQ_W-1:0] mask_q;
  logic [rta_pkg::IRQ_W-1:0] mask_d;
  logic                    start_q;
  logic                    start_d;

  // bus and interrupt line state
  logic [31:0]             prdata_d;
  logic                    pready_d;
  logic                    pslverr_d;
  logic                    irq_d;

  // event detection state and merit selection terms
  logic                    lock_prev_q;
  logic                    sig_prev_q;
  logic                    merit_h_d;
  logic                    merit_v_d;
  logic                    merit_alt_d;

  // decode
  logic [7:0]              idx;
  logic                    addr_ok;
  logic                    mapped;
  logic                    wr_fire;
  logic [31:0]             rd_value;

  // event terms
  logic                    lock_loss_evt;
  logic                    sig_loss_evt;
  logic                    eye_low_evt;
  logic [rta_pkg::IRQ_W-1:0] set_vec;
  logic [rta_pkg::IRQ_W-1:0] clr_vec;

  // compare results
  logic                    irq_h_ok;
  logic                    irq_v_ok;
  logic                    dfe_h_ok;
  logic                    dfe_v_ok;

  rta_eye_cmp u_irq_cmp
  (
    .horizontal_eye_opening (horizontal_eye_opening),
    .vertical_eye_opening   (vertical_eye_opening),
    .level_h                (eye_irq_q[rta_pkg::THR_H_LSB +: 4]),
    .level_v                (eye_irq_q[rta_pkg::THR_V_LSB +: 4]),
    .h_ok                   (irq_h_ok),
    .v_ok                   (irq_v_ok)
  );

  rta_eye_cmp u_dfe_cmp
  (
    .horizontal_eye_opening (horizontal_eye_opening),
    .vertical_eye_opening   (vertical_eye_opening),
    .level_h                (dfe_min_q[rta_pkg::THR_H_LSB +: 4]),
    .level_v                (dfe_min_q[rta_pkg::THR_V_LSB +: 4]),
    .h_ok                   (dfe_h_ok),
    .v_ok                   (dfe_v_ok)
  );

  rta_adapt_seq u_seq
  (
    .clk              (clk),
    .rst              (rst),
    .policy           (ctrl_q[rta_pkg::CTRL_POLICY_LSB +: 2]),
    .start            (start_q),
    .cdr_lock         (cdr_lock),
    .eye_min_met      (dfe_h_ok && dfe_v_ok),
    .ctle_done        (ctle_done),
    .dfe_done         (dfe_done),
    .ctle_adapt_q     (ctle_adapt),
    .dfe_adapt_q      (dfe_adapt),
    .eq_final_adapt_q (eq_final_adapt),
    .busy_q           (adapt_busy)
  );

  // address decode: word aligned, index in bits 9:2, upper bits zero
  always_comb
  begin
    idx     = paddr[9:2];
    addr_ok = (paddr[1:0] == 2'h0) && (paddr[11:10] == 2'h0);
    mapped  = 1'b0;
    if (addr_ok)
    begin
      unique case (idx)
        rta_pkg::IDX_LOSS_OBS,
        rta_pkg::IDX_CTRL,
        rta_pkg::IDX_EYE_IRQ,
        rta_pkg::IDX_DFE_MIN,
        rta_pkg::IDX_IRQ_STATUS,
        rta_pkg::IDX_IRQ_MASK,
        rta_pkg::IDX_AUX_CTRL,
        rta_pkg::IDX_ALT_FOM: mapped = 1'b1;
        default:              mapped = 1'b0;
      endcase
    end
    wr_fire = psel && penable && pready && pwrite && mapped;
  end

  // read mux; narrow registers sit in the low bits
  always_comb
  begin
    rd_value = 32'h0000_0000;
    unique case (idx)
      rta_pkg::IDX_LOSS_OBS:
      begin
        rd_value[rta_pkg::OBS_LOCK_LOSS] = status_q[rta_pkg::IRQ_LOCK_LOSS];
        rd_value[rta_pkg::OBS_SIG_LOSS]  = status_q[rta_pkg::IRQ_SIG_LOSS];
      end
      rta_pkg::IDX_CTRL:       rd_value[7:0] = ctrl_q;
      rta_pkg::IDX_EYE_IRQ:    rd_value[7:0] = eye_irq_q;
      rta_pkg::IDX_DFE_MIN:    rd_value[7:0] = dfe_min_q;
      rta_pkg::IDX_IRQ_STATUS: rd_value[rta_pkg::IRQ_W-1:0] = status_q;
      rta_pkg::IDX_IRQ_MASK:   rd_value[rta_pkg::IRQ_W-1:0] = mask_q;
      rta_pkg::IDX_AUX_CTRL:   rd_value[7:0] = aux_q;
      rta_pkg::IDX_ALT_FOM:    rd_value[7:0] = alt_q;
      default:                 rd_value = 32'h0000_0000;
    endcase
  end

  // bus answer: ready one cycle after setup, data and error captured with it
  // zero wait states, so every access ends in its first access cycle
  always_comb
  begin
    pready_d  = psel && !penable;
    prdata_d  = prdata;
    pslverr_d = 1'b0;
    if (psel && !penable)
    begin
      prdata_d  = (mapped && !pwrite) ? rd_value : 32'h0000_0000;
      pslverr_d = !mapped;
    end
  end

  // register writes; a refused address writes nothing and pslverr reports it
  // register writes
  always_comb
  begin
    ctrl_d    = ctrl_q;
    eye_irq_d = eye_irq_q;
    dfe_min_d = dfe_min_q;
    aux_d     = aux_q;
    alt_d     = alt_q;
    mask_d    = mask_q;
    start_d   = 1'b0;
    clr_vec   = '0;
    if (wr_fire)
    begin
      unique case (idx)
        rta_pkg::IDX_CTRL:       ctrl_d    = pwdata[7:0];
        rta_pkg::IDX_EYE_IRQ:    eye_irq_d = pwdata[7:0];
        rta_pkg::IDX_DFE_MIN:    dfe_min_d = pwdata[7:0];
        rta_pkg::IDX_IRQ_MASK:   mask_d    = pwdata[rta_pkg::IRQ_W-1:0];
        rta_pkg::IDX_IRQ_STATUS: clr_vec   = pwdata[rta_pkg::IRQ_W-1:0];
        rta_pkg::IDX_LOSS_OBS:
        begin
          clr_vec[rta_pkg::IRQ_LOCK_LOSS] = pwdata[rta_pkg::OBS_LOCK_LOSS];
          clr_vec[rta_pkg::IRQ_SIG_LOSS]  = pwdata[rta_pkg::OBS_SIG_LOSS];
        end
        rta_pkg::IDX_AUX_CTRL:
        begin
          aux_d                       = pwdata[7:0];
          aux_d[rta_pkg::AUX_START]   = 1'b0;
          start_d                     = pwdata[rta_pkg::AUX_START];
        end
        rta_pkg::IDX_ALT_FOM:    alt_d     = pwdata[7:0];
        default:                 ctrl_d    = ctrl_q;
      endcase
    end
  end

  // events; lock and detect inputs are synchronous, so a one-flop edge detect is enough
  // enables gate only the setting, so turning one off leaves a set bit for software
  always_comb
  begin
    lock_loss_evt = lock_prev_q && !cdr_lock;
    sig_loss_evt  = sig_prev_q && !signal_detect;
    eye_low_evt   = eye_valid && !(irq_h_ok && irq_v_ok);
    set_vec       = '0;
    set_vec[rta_pkg::IRQ_PATTERN]   = pattern_error_pulse && ctrl_q[rta_pkg::CTRL_PAT_IRQ_EN];
    set_vec[rta_pkg::IRQ_LOCK_LOSS] = lock_loss_evt && ctrl_q[rta_pkg::CTRL_LOCK_IRQ_EN];
    set_vec[rta_pkg::IRQ_SIG_LOSS]  = sig_loss_evt && ctrl_q[rta_pkg::CTRL_LOSS_IRQ_EN];
    set_vec[rta_pkg::IRQ_EYE_LOW]   = eye_low_evt && aux_q[rta_pkg::AUX_EYE_IRQ_EN];
    // a new event in the clearing cycle survives the clear
    status_d = (status_q & ~clr_vec) | set_vec;
    irq_d    = |(status_d & mask_d);
  end

  // merit selection; the alternate bit wins over the field
  always_comb
  begin
    merit_alt_d = alt_q[rta_pkg::ALT_FOM_BIT];
    merit_h_d   = 1'b0;
    merit_v_d   = 1'b0;
    if (!merit_alt_d)
    begin
      unique case (ctrl_q[rta_pkg::CTRL_MERIT_LSB +: 2])
        rta_pkg::MER_H:
          merit_h_d = 1'b1;
        rta_pkg::MER_V:
          merit_v_d = 1'b1;
        rta_pkg::MER_BOTH_A,
        rta_pkg::MER_BOTH_B:
        begin
          merit_h_d = 1'b1;
          merit_v_d = 1'b1;
        end
      endcase
    end
  end

  // configuration registers; the start strobe lives for one cycle only
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      ctrl_q    <= rta_pkg::RST_CTRL;
      eye_irq_q <= rta_pkg::RST_EYE_IRQ;
      dfe_min_q <= rta_pkg::RST_DFE_MIN;
      aux_q     <= rta_pkg::RST_AUX;
      alt_q     <= rta_pkg::RST_ALT_FOM;
      mask_q    <= rta_pkg::RST_IRQ;
      start_q   <= 1'b0;
    end
    else
    begin
      ctrl_q    <= ctrl_d;
      eye_irq_q <= eye_irq_d;
      dfe_min_q <= dfe_min_d;
      aux_q     <= aux_d;
      alt_q     <= alt_d;
      mask_q    <= mask_d;
      start_q   <= start_d;
    end
  end

  // sticky status, interrupt line and the loss edge detectors
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      status_q    <= rta_pkg::RST_IRQ;
      irq         <= 1'b0;
      lock_prev_q <= 1'b0;
      sig_prev_q  <= 1'b0;
    end
    else
    begin
      status_q    <= status_d;
      irq         <= irq_d;
      lock_prev_q <= cdr_lock;
      sig_prev_q  <= signal_detect;
    end
  end

  // bus answer registers
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      prdata  <= 32'h0000_0000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      prdata  <= prdata_d;
      pready  <= pready_d;
      pslverr <= pslverr_d;
    end
  end

  // merit outputs; reset shows the default field, both openings scored
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
    begin
      merit_use_horizontal <= 1'b1;
      merit_use_vertical   <= 1'b1;
      merit_use_alternate  <= 1'b0;
    end
    else
    begin
      merit_use_horizontal <= merit_h_d;
      merit_use_vertical   <= merit_v_d;
      merit_use_alternate  <= merit_alt_d;
    end
  end
endmodule

/* tb/rta_bank_sva.sv */
// checker for the adaptation and interrupt configuration bank
`timescale 1ns/100ps
module rta_bank_sva
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        irq,
  input wire logic        ctle_adapt,
  input wire logic        dfe_adapt,
  input wire logic        eq_final_adapt,
  input wire logic        adapt_busy,
  input wire logic        merit_use_horizontal,
  input wire logic        merit_use_vertical,
  input wire logic        merit_use_alternate
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ready_after_setup_a: assert property (psel && !penable |=> pready)
    else $error("no answer after setup");
  ready_one_cycle_a: assert property (pready |=> !pready)
    else $error("pready held too long");
  err_zero_data_a: assert property (pslverr |-> pready && prdata == 32'h0)
    else $error("error answer without zero data");
  merit_alt_excl_a: assert property (merit_use_alternate |-> !merit_use_horizontal && !merit_use_vertical)
    else $error("alternate merit not exclusive");
  merit_some_eye_a: assert property (!merit_use_alternate |-> merit_use_horizontal || merit_use_vertical)
    else $error("no eye opening scored");
  phase_excl_a: assert property ($onehot0({ctle_adapt, dfe_adapt, eq_final_adapt}))
    else $error("two adaptation phases at once");
  phase_busy_a: assert property (ctle_adapt || dfe_adapt || eq_final_adapt |-> adapt_busy)
    else $error("phase active while not busy");
  dfe_after_ctle_a: assert property ($rose(dfe_adapt) |-> $past(ctle_adapt))
    else $error("dfe phase not entered from ctle");
  eq_after_dfe_a: assert property ($rose(eq_final_adapt) |-> $past(dfe_adapt))
    else $error("final phase not entered from dfe");
  irq_fall_write_a: assert property ($fell(irq) |->
    $past(psel && penable && pwrite) || $past(psel && penable && pwrite, 2))
    else $error("irq dropped without a register write");
endmodule

bind rta_bank rta_bank_sva chk (.clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .ctle_adapt(ctle_adapt),
  .dfe_adapt(dfe_adapt), .eq_final_adapt(eq_final_adapt), .adapt_busy(adapt_busy),
  .merit_use_horizontal(merit_use_horizontal), .merit_use_vertical(merit_use_vertical),
  .merit_use_alternate(merit_use_alternate));

/* tb/rta_bank_tb.sv */
// self-checking testbench for the adaptation and interrupt configuration bank
`timescale 1ns/100ps
`define CHK(got, exp) begin check_count++; if ((got) !== (exp)) begin n_errors++; \
  $display("[ERR] t=%0t got=%h exp=%h", $time, (got), (exp)); end end
module rta_bank_tb;
  logic        clk, rst, psel, penable, pwrite, er;
  logic        pattern_error_pulse, cdr_lock, signal_detect, eye_valid, ctle_done, dfe_done;
  logic        pready, pslverr, irq, ctle_adapt, dfe_adapt, eq_final_adapt, adapt_busy;
  logic        merit_use_horizontal, merit_use_vertical, merit_use_alternate;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0]  horizontal_eye_opening, vertical_eye_opening;
  logic [2:0]  mexp [4] = '{3'h3, 3'h2, 3'h1, 3'h3};
  int          n_errors, check_count;

  rta_bank uut (.clk, .rst, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .pattern_error_pulse, .cdr_lock, .signal_detect, .eye_valid, .horizontal_eye_opening,
    .vertical_eye_opening, .ctle_done, .dfe_done, .irq, .ctle_adapt, .dfe_adapt, .eq_final_adapt,
    .adapt_busy, .merit_use_horizontal, .merit_use_vertical, .merit_use_alternate);

  always #10 clk = ~clk;

  task summarize;
    $display("errors=%0d checks=%0d", n_errors, check_count);
    if (n_errors == 0 && check_count > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  // the request is held until pready is seen high at a rising edge
  task apb(input logic w, input logic [7:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= {2'b00, idx, 2'b00}; pwdata <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin @(posedge clk); n++; end while (pready !== 1'b1 && n < 20);
    if (n >= 20)
    begin
      n_errors++;
      summarize();
    end
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task wr(input logic [7:0] idx, input logic [31:0] d); apb(1'b1, idx, d); endtask
  task rchk(input logic [7:0] idx, input logic [31:0] e); apb(1'b0, idx, 32'h0); `CHK(rd, e) endtask
  task cyc(input int n); repeat (n) @(posedge clk); endtask

  task pulse(input int w);
    @(posedge clk);
    case (w)
      0: ctle_done <= 1'b1;
      1: dfe_done <= 1'b1;
      2: pattern_error_pulse <= 1'b1;
      default: eye_valid <= 1'b1;
    endcase
    @(posedge clk);
    {ctle_done, dfe_done, pattern_error_pulse, eye_valid} <= 4'h0;
  endtask

  // state vector: busy, ctle, dfe, final
  task wait_st(input logic [3:0] e);
    int n;
    n = 0;
    while ({adapt_busy, ctle_adapt, dfe_adapt, eq_final_adapt} !== e && n < 40)
    begin
      @(posedge clk);
      n++;
    end
    `CHK({adapt_busy, ctle_adapt, dfe_adapt, eq_final_adapt}, e)
    if (n >= 40)
      summarize();
  endtask

  task t_reset;
    rchk(8'h31, 32'h20);
    rchk(8'h32, 32'h11);
    rchk(8'h33, 32'h88);
    rchk(8'h40, 32'h0);
    apb(1'b0, 8'h50, 32'h0);
    `CHK({er, rd}, 33'h100000000)
    $display("test reset done");
  endtask

  task t_regs;
    for (int i = 0; i < 3; i++)
    begin
      wr(8'(8'h31 + i), 32'hFFFFFF5A ^ i);
      rchk(8'(8'h31 + i), 32'h5A ^ i);
    end
    $display("test regs done");
  endtask

  task t_merit;
    for (int m = 0; m < 4; m++)
    begin
      wr(8'h31, 32'(m << 3));
      cyc(2);
      `CHK({merit_use_alternate, merit_use_horizontal, merit_use_vertical}, mexp[m])
    end
    wr(8'h6E, 32'h80);
    cyc(2);
    `CHK({merit_use_alternate, merit_use_horizontal, merit_use_vertical}, 3'h4)
    wr(8'h6E, 32'h0);
    $display("test merit done");
  endtask

  task t_irq;
    wr(8'h41, 32'hF);
    pulse(2);
    {cdr_lock, signal_detect} <= 2'b00;
    cyc(2);
    rchk(8'h40, 32'h0);
    `CHK(irq, 1'b0)
    {cdr_lock, signal_detect} <= 2'b11;
    wr(8'h31, 32'h83);
    pulse(2);
    cdr_lock <= 1'b0;
    cyc(2);
    rchk(8'h01, 32'h20);
    signal_detect <= 1'b0;
    cyc(2);
    rchk(8'h01, 32'h21);
    rchk(8'h40, 32'hB);
    `CHK(irq, 1'b1)
    wr(8'h41, 32'h0);
    cyc(2);
    `CHK(irq, 1'b0)
    wr(8'h40, 32'hF);
    rchk(8'h40, 32'h0);
    {cdr_lock, signal_detect} <= 2'b11;
    wr(8'h31, 32'h0);
    wr(8'h41, 32'hF);
    wr(8'h32, 32'h21);
    wr(8'h42, 32'h2);
    horizontal_eye_opening <= 8'h10;
    vertical_eye_opening <= 8'h08;
    pulse(3);
    rchk(8'h40, 32'h0);
    vertical_eye_opening <= 8'h07;
    pulse(3);
    rchk(8'h40, 32'h4);
    `CHK(irq, 1'b1)
    wr(8'h40, 32'hF);
    wr(8'h42, 32'h0);
    pulse(3);
    rchk(8'h40, 32'h0);
    $display("test irq done");
  endtask

  task t_seq;
    wr(8'h31, 32'h20);
    wr(8'h42, 32'h1);
    wait_st(4'hC);
    pulse(0);
    wait_st(4'h0);
    wr(8'h31, 32'h40);
    wr(8'h42, 32'h1);
    wait_st(4'hC);
    pulse(0);
    wait_st(4'hA);
    pulse(1);
    wait_st(4'hC);
    pulse(0);
    wait_st(4'h0);
    cdr_lock <= 1'b0;
    horizontal_eye_opening <= 8'h3F;
    vertical_eye_opening <= 8'h40;
    // an earlier scenario left other minimums behind; restore eight steps each
    wr(8'h33, 32'h88);
    wr(8'h31, 32'h60);
    wr(8'h42, 32'h1);
    wait_st(4'hC);
    pulse(0);
    cdr_lock <= 1'b1;
    cyc(6);
    `CHK({adapt_busy, ctle_adapt, dfe_adapt, eq_final_adapt}, 4'hC)
    horizontal_eye_opening <= 8'h40;
    wait_st(4'hA);
    pulse(1);
    wait_st(4'h9);
    pulse(0);
    wait_st(4'h0);
    wr(8'h31, 32'h0);
    wr(8'h42, 32'h1);
    cyc(6);
    `CHK({adapt_busy, ctle_adapt, dfe_adapt, eq_final_adapt}, 4'h0)
    $display("test sequencer done");
  endtask

  initial
  begin
    clk = 1'b0;
    rst = 1'b1;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {pattern_error_pulse, eye_valid, ctle_done, dfe_done} = 4'h0;
    {cdr_lock, signal_detect} = 2'b11;
    horizontal_eye_opening = 8'h0;
    vertical_eye_opening = 8'h0;
    n_errors = 0;
    check_count = 0;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    t_reset();
    t_regs();
    t_merit();
    t_irq();
    t_seq();
    summarize();
  end
endmodule
